/* logic/ldr_defines.svh */
// Offsets, field positions, reset values and codes for the DMA register set.
// Assumes inclusion by bare name from the package and both ends.
`ifndef LDR_DEFINES_SVH
`define LDR_DEFINES_SVH

// Device register offsets on ain
`define LDR_A_CMD      4'h8
`define LDR_A_REQ      4'h9
`define LDR_A_MASK1    4'ha
`define LDR_A_MODE     4'hb
`define LDR_A_CLRBP    4'hc
`define LDR_A_MCLR     4'hd
`define LDR_A_UNMASK   4'he
`define LDR_A_MASKALL  4'hf

// Command fields
`define LDR_C_M2M      0
`define LDR_C_HOLD     1
`define LDR_C_DIS      2
`define LDR_C_COMP     3
`define LDR_C_ROT      4
`define LDR_C_EXTW     5
`define LDR_C_REQLO    6
`define LDR_C_ACKHI    7

// Mode fields and codes
`define LDR_M_CH       1:0
`define LDR_M_TYPE     3:2
`define LDR_M_AUTO     4
`define LDR_M_DEC      5
`define LDR_M_SVC      7:6
`define LDR_T_WRITE    2'h1
`define LDR_T_READ     2'h2
`define LDR_S_DEMAND   2'h0
`define LDR_S_SINGLE   2'h1
`define LDR_S_BLOCK    2'h2
`define LDR_SET_BIT    2

// Reset values and limits
`define LDR_CNT_WRAP   16'hffff
`define LDR_MASK_RST   4'hf
`define LDR_ZERO8      8'h00

// Host register offsets and command fields
`define LDR_H_DATA     2'h0
`define LDR_H_CMD      2'h1
`define LDR_H_RES      2'h2
`define LDR_HC_REG     3:0
`define LDR_HC_WORD    4
`define LDR_HC_READ    5

`endif

/* logic/ldr_pkg.sv */
// Types shared by both ends of the DMA register link.
// Assumes ldr_defines.svh is on the include path.
`include "ldr_defines.svh"

package ldr_pkg;

   typedef enum logic [2:0] {
      st_idle, st_hold, st_addr, st_read, extra_transfer_state, st_end
   } ldr_xfer_t;

   typedef enum logic [2:0] {
      hs_idle, hs_clear, hs_low, hs_high, hs_drain
   } ldr_host_t;

endpackage

/* logic/ldr_if.sv */
// Pins between the host processor and the DMA device.
// Assumes both ends run on the same clk_sys.
`timescale 1ns/1ps
`default_nettype none

interface ldr_if;
   logic       cs_n;
   logic       iorin_n;
   logic       iowin_n;
   logic [3:0] ain;
   logic [7:0] dbin;
   logic [7:0] dbout;
   logic       hreq;
   logic       hlda;

   modport dev  (input cs_n, iorin_n, iowin_n, ain, dbin, hlda,
                 output dbout, hreq);
   modport host (output cs_n, iorin_n, iowin_n, ain, dbin, hlda,
                 input dbout, hreq);
endinterface

`default_nettype wire

/* logic/ldr_device.sv */
// Four-channel DMA device: register set and transfer state machine.
// Assumes host strobes are synchronous to clk_sys and one cycle per access.
`timescale 1ns/1ps
`default_nettype none
`include "ldr_defines.svh"

module ldr_device
   import ldr_pkg::*;
(
   // System
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // Host link
   ldr_if.dev               bus,
   // Peripheral and memory side
   input  wire logic [3:0]  dreq,
   input  wire logic [7:0]  mem_rdata,
   output logic      [3:0]  dack,
   output logic      [15:0] aout,
   output logic             aen,
   output logic             memr_n,
   output logic             memw_n,
   output logic             iorout_n,
   output logic             iowout_n,
   output logic             eopout_n
);

   logic [15:0] base_a_q [4];
   logic [15:0] base_c_q [4];
   logic [15:0] cur_a_q  [4];
   logic [15:0] cur_c_q  [4];
   logic [7:0]  mode_q   [4];
   logic [7:0]  cmd_q;
   logic [7:0]  temp_q;
   logic [3:0]  mask_q;
   logic [3:0]  swreq_q;
   logic [3:0]  tc_q;
   logic        bp_q;
   ldr_xfer_t   st_q;
   ldr_xfer_t   st_d;
   logic [1:0]  ch_q;
   logic [1:0]  last_q;
   logic        m2m_q;
   logic        pass_q;
   logic        wr_on_q;
   logic [7:0]  rdat;

   function automatic [1:0] pick(input [3:0] r, input [1:0] first);
      logic [1:0] idx;
      pick = first;
      for (int i = 3; i >= 0; i--) begin
         idx = first + 2'(i);
         if (r[idx])
            pick = idx;
      end
   endfunction

   function automatic [15:0] put_byte(input [15:0] w, input hi,
                                      input [7:0] b);
      put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
   endfunction

   wire       wr      = ~bus.cs_n & ~bus.iowin_n;
   wire       rd      = ~bus.cs_n & ~bus.iorin_n;
   wire       idle    = (st_q == st_idle);
   wire       mclr    = wr & (bus.ain == `LDR_A_MCLR);
   wire       chreg   = ~bus.ain[3];
   wire [1:0] rch     = bus.ain[2:1];
   wire [1:0] dch     = bus.dbin[`LDR_M_CH];
   wire [3:0] active  = dreq ^ {4{cmd_q[`LDR_C_REQLO]}};
   wire [3:0] want    = (active & ~mask_q) | swreq_q;
   wire [7:0] md      = mode_q[ch_q];
   wire       tc_now  = (cur_c_q[ch_q] == 16'h0000);
   wire       at_end  = (st_q == st_end);
   wire       count   = at_end & ~(m2m_q & ~pass_q);
   wire       finish  = count & tc_now;
   wire       comp    = cmd_q[`LDR_C_COMP] & ~m2m_q;
   wire [1:0] first   = cmd_q[`LDR_C_ROT] ? last_q + 2'h1 : 2'h0;

   // Transfer sequencing
   always_comb begin
      st_d = st_q;
      case (st_q)
         st_idle:
            if (~cmd_q[`LDR_C_DIS] & |want & ~mclr)
               st_d = st_hold;
         st_hold:
            if (bus.hlda)
               st_d = st_addr;
         st_addr:
            st_d = st_read;
         st_read:
            st_d = comp ? st_end : extra_transfer_state;
         extra_transfer_state:
            st_d = st_end;
         st_end:
            if (m2m_q & ~pass_q)
               st_d = st_addr;
            else if (tc_now)
               st_d = st_idle;
            else if (m2m_q || md[`LDR_M_SVC] == `LDR_S_BLOCK)
               st_d = st_addr;
            else if (md[`LDR_M_SVC] == `LDR_S_DEMAND && want[ch_q])
               st_d = st_addr;
            else
               st_d = st_idle;
         default:
            st_d = st_idle;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset)
         st_q <= st_idle;
      else if (mclr)
         st_q <= st_idle;
      else
         st_q <= st_d;
   end

   // Channel choice and memory-to-memory pass
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ch_q   <= 2'h0;
         last_q <= 2'h3;
         m2m_q  <= 1'b0;
         pass_q <= 1'b0;
      end else if (idle && st_d == st_hold) begin
         m2m_q  <= cmd_q[`LDR_C_M2M] & want[0];
         pass_q <= 1'b0;
         ch_q   <= (cmd_q[`LDR_C_M2M] & want[0]) ? 2'h0 : pick(want, first);
      end else if (at_end & m2m_q & ~pass_q) begin
         pass_q <= 1'b1;
         ch_q   <= 2'h1;
      end else if (at_end & m2m_q) begin
         pass_q <= 1'b0;
         ch_q   <= 2'h0;
         if (st_d == st_idle)
            last_q <= 2'h1;
      end else if (at_end && st_d == st_idle) begin
         last_q <= ch_q;
      end
   end

   // Channel address and count registers
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 4; i++) begin
            base_a_q[i] <= 16'h0000;
            base_c_q[i] <= 16'h0000;
            cur_a_q[i]  <= 16'h0000;
            cur_c_q[i]  <= 16'h0000;
         end
      end else if (wr & chreg & idle) begin
         if (bus.ain[0]) begin
            base_c_q[rch] <= put_byte(base_c_q[rch], bp_q, bus.dbin);
            cur_c_q[rch]  <= put_byte(cur_c_q[rch], bp_q, bus.dbin);
         end else begin
            base_a_q[rch] <= put_byte(base_a_q[rch], bp_q, bus.dbin);
            cur_a_q[rch]  <= put_byte(cur_a_q[rch], bp_q, bus.dbin);
         end
      end else if (at_end) begin
         if (finish & md[`LDR_M_AUTO]) begin
            cur_a_q[ch_q] <= base_a_q[ch_q];
            cur_c_q[ch_q] <= base_c_q[ch_q];
         end else begin
            if (count)
               cur_c_q[ch_q] <= cur_c_q[ch_q] - 16'h0001;
            if (!(m2m_q & ~pass_q & cmd_q[`LDR_C_HOLD]))
               cur_a_q[ch_q] <= md[`LDR_M_DEC] ? cur_a_q[ch_q] - 16'h0001
                                               : cur_a_q[ch_q] + 16'h0001;
         end
      end
   end

   // Byte pointer
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset)
         bp_q <= 1'b0;
      else if (mclr || (wr && bus.ain == `LDR_A_CLRBP))
         bp_q <= 1'b0;
      else if ((wr | rd) & chreg)
         bp_q <= ~bp_q;
   end

   // Command and mode registers
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cmd_q <= `LDR_ZERO8;
         for (int i = 0; i < 4; i++)
            mode_q[i] <= `LDR_ZERO8;
      end else if (mclr) begin
         cmd_q <= `LDR_ZERO8;
         for (int i = 0; i < 4; i++)
            mode_q[i] <= `LDR_ZERO8;
      end else if (wr & idle) begin
         if (bus.ain == `LDR_A_CMD)
            cmd_q <= bus.dbin;
         if (bus.ain == `LDR_A_MODE)
            mode_q[dch] <= bus.dbin;
      end
   end

   // Mask and software request bits
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mask_q  <= `LDR_MASK_RST;
         swreq_q <= 4'h0;
      end else if (mclr) begin
         mask_q  <= `LDR_MASK_RST;
         swreq_q <= 4'h0;
      end else begin
         if (wr && bus.ain == `LDR_A_MASK1)
            mask_q[dch] <= bus.dbin[`LDR_SET_BIT];
         if (wr && bus.ain == `LDR_A_UNMASK)
            mask_q <= 4'h0;
         if (wr && bus.ain == `LDR_A_MASKALL)
            mask_q <= bus.dbin[3:0];
         if (wr && bus.ain == `LDR_A_REQ)
            swreq_q[dch] <= bus.dbin[`LDR_SET_BIT];
         if (finish) begin
            mask_q[ch_q]  <= 1'b1;
            swreq_q[ch_q] <= 1'b0;
         end
      end
   end

   // Terminal count status, set wins over read clear
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset)
         tc_q <= 4'h0;
      else if (mclr)
         tc_q <= 4'h0;
      else
         tc_q <= (tc_q & ~{4{rd && bus.ain == `LDR_A_CMD}})
                 | ({3'h0, finish} << ch_q);
   end

   // Temporary register
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset)
         temp_q <= `LDR_ZERO8;
      else if (mclr)
         temp_q <= `LDR_ZERO8;
      else if (at_end & m2m_q & ~pass_q)
         temp_q <= mem_rdata;
   end

   // Register read mux; base registers have no read path
   always_comb begin
      rdat = `LDR_ZERO8;
      if (chreg)
         rdat = bus.ain[0] ? (bp_q ? cur_c_q[rch][15:8] : cur_c_q[rch][7:0])
                           : (bp_q ? cur_a_q[rch][15:8] : cur_a_q[rch][7:0]);
      else if (bus.ain == `LDR_A_CMD)
         rdat = {active | swreq_q, tc_q};
      else if (bus.ain == `LDR_A_MCLR && idle)
         rdat = temp_q;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset)
         bus.dbout <= `LDR_ZERO8;
      else if (rd)
         bus.dbout <= rdat;
      else if (m2m_q & pass_q)
         bus.dbout <= temp_q;
   end

   // Bus request, address, acknowledge, read strobes, end of process
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bus.hreq <= 1'b0;
         aen      <= 1'b0;
         aout     <= 16'h0000;
         dack     <= 4'h0;
         memr_n   <= 1'b1;
         iorout_n <= 1'b1;
         eopout_n <= 1'b1;
         wr_on_q  <= 1'b0;
      end else begin
         bus.hreq <= (st_d != st_idle);
         aen      <= (st_d != st_idle) & (st_d != st_hold);
         aout     <= cur_a_q[ch_q];
         dack     <= ({3'h0, aen} << ch_q)
                     ^ {4{~cmd_q[`LDR_C_ACKHI]}};
         memr_n   <= ~((st_d == st_read || st_d == extra_transfer_state)
                     & (m2m_q ? ~pass_q
                              : md[`LDR_M_TYPE] == `LDR_T_READ));
         iorout_n <= ~((st_d == st_read || st_d == extra_transfer_state)
                     & ~m2m_q & (md[`LDR_M_TYPE] == `LDR_T_WRITE));
         wr_on_q  <= (st_d == extra_transfer_state)
                     | ((st_d == st_read)
                        & (cmd_q[`LDR_C_EXTW] | comp));
         eopout_n <= ~finish;
      end
   end

   // Write strobes launched from the falling edge
   always_ff @(negedge clk_sys or posedge reset) begin
      if (reset) begin
         memw_n   <= 1'b1;
         iowout_n <= 1'b1;
      end else begin
         memw_n   <= ~(wr_on_q & (m2m_q ? pass_q
                        : md[`LDR_M_TYPE] == `LDR_T_WRITE));
         iowout_n <= ~(wr_on_q & ~m2m_q
                       & (md[`LDR_M_TYPE] == `LDR_T_READ));
      end
   end

endmodule // ldr_device

`default_nettype wire

/* logic/ldr_host.sv */
// Host processor end: turns software orders into device register accesses.
// Assumes the device answers reads one clock after the strobe edge.
`timescale 1ns/1ps
`default_nettype none
`include "ldr_defines.svh"

module ldr_host
   import ldr_pkg::*;
(
   // System
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // Device link
   ldr_if.host              bus,
   // Software port
   input  wire logic [1:0]  sw_addr,
   input  wire logic [15:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic      [15:0] sw_rdata
);

   ldr_host_t   st_q;
   logic [15:0] data_q;
   logic [15:0] res_q;
   logic [5:0]  ord_q;
   logic        err_q;
   logic [1:0]  svc_q [4];
   logic [1:0]  p1_q;
   logic [1:0]  p2_q;

   wire       busy  = (st_q != hs_idle);
   wire       go    = sw_wr & (sw_addr == `LDR_H_CMD) & ~busy;
   wire       is_rq = ~sw_wdata[`LDR_HC_READ]
                      & (sw_wdata[`LDR_HC_REG] == `LDR_A_REQ);
   wire       bad   = is_rq & data_q[`LDR_SET_BIT]
                      & (svc_q[data_q[`LDR_M_CH]] != `LDR_S_BLOCK);
   wire       free  = ~bus.hreq & ~bus.hlda;
   wire       strb  = free & (st_q == hs_low || st_q == hs_high);
   wire       rdop  = ord_q[`LDR_HC_READ];

   // Order sequencing
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         st_q  <= hs_idle;
         ord_q <= 6'h00;
         err_q <= 1'b0;
      end else begin
         case (st_q)
            hs_idle:
               if (go) begin
                  err_q <= bad;
                  ord_q <= sw_wdata[5:0];
                  if (!bad)
                     st_q <= sw_wdata[`LDR_HC_WORD] ? hs_clear : hs_low;
               end
            hs_clear:
               if (free)
                  st_q <= hs_low;
            hs_low:
               if (free)
                  st_q <= ord_q[`LDR_HC_WORD] ? hs_high : hs_drain;
            hs_high:
               if (free)
                  st_q <= hs_drain;
            hs_drain:
               if (!p1_q[1])
                  st_q <= hs_idle;
            default:
               st_q <= hs_idle;
         endcase
      end
   end

   // Strobe pins, one cycle per access
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bus.cs_n    <= 1'b1;
         bus.iorin_n <= 1'b1;
         bus.iowin_n <= 1'b1;
         bus.ain     <= 4'h0;
         bus.dbin    <= `LDR_ZERO8;
      end else begin
         bus.cs_n    <= ~(strb | (free & st_q == hs_clear));
         bus.iorin_n <= ~(strb & rdop);
         bus.iowin_n <= ~((strb & ~rdop) | (free & st_q == hs_clear));
         bus.ain     <= (st_q == hs_clear) ? `LDR_A_CLRBP
                                           : ord_q[`LDR_HC_REG];
         bus.dbin    <= (st_q == hs_high) ? data_q[15:8] : data_q[7:0];
      end
   end

   // Read capture two edges after the strobe
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         p1_q  <= 2'h0;
         p2_q  <= 2'h0;
         res_q <= 16'h0000;
      end else begin
         p1_q <= {strb & rdop, st_q == hs_high};
         p2_q <= p1_q;
         if (p2_q[1]) begin
            if (p2_q[0])
               res_q[15:8] <= bus.dbout;
            else
               res_q <= {8'h00, bus.dbout};
         end
      end
   end

   // Software data and shadow of each channel's service mode
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         data_q <= 16'h0000;
         for (int i = 0; i < 4; i++)
            svc_q[i] <= 2'h0;
      end else begin
         if (sw_wr && sw_addr == `LDR_H_DATA && !busy)
            data_q <= sw_wdata;
         if (go && !sw_wdata[`LDR_HC_READ]
             && sw_wdata[`LDR_HC_REG] == `LDR_A_MODE)
            svc_q[data_q[`LDR_M_CH]] <= data_q[`LDR_M_SVC];
         if (go && !sw_wdata[`LDR_HC_READ]
             && sw_wdata[`LDR_HC_REG] == `LDR_A_MCLR)
            for (int i = 0; i < 4; i++)
               svc_q[i] <= 2'h0;
      end
   end

   // Software read port and bus grant
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sw_rdata <= 16'h0000;
         bus.hlda <= 1'b0;
      end else begin
         bus.hlda <= bus.hreq;
         if (sw_rd)
            case (sw_addr)
               `LDR_H_DATA: sw_rdata <= data_q;
               `LDR_H_CMD:  sw_rdata <= {13'h0000, bus.hlda, err_q, busy};
               `LDR_H_RES:  sw_rdata <= res_q;
               default:     sw_rdata <= 16'h0000;
            endcase
      end
   end

endmodule // ldr_host

`default_nettype wire

/* tb/ldr_link_monitor.sv */
// Checker on the host-to-device register link.
// Assumes one clk_sys domain and the ldr_if signals as plain inputs.
`timescale 1ns/1ps
`default_nettype none
`include "ldr_defines.svh"

module ldr_link_monitor (
   // System
   input wire logic       clk_sys,
   input wire logic       reset,
   // Link
   input wire logic       cs_n,
   input wire logic       iorin_n,
   input wire logic       iowin_n,
   input wire logic [3:0] ain,
   input wire logic [7:0] dbout,
   input wire logic       hreq,
   input wire logic       hlda
);
   logic       rd;
   logic       wr;
   logic       tc_ok_q;
   logic       tmp_ok_q;
   logic       ptr_q;
   logic [3:0] last_q;

   assign rd = !cs_n && !iorin_n;
   assign wr = !cs_n && !iowin_n;

   // No transfer since a clear, or for tc_ok_q since a status read
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tc_ok_q  <= 1'b1;
         tmp_ok_q <= 1'b1;
      end else if (hreq) begin
         tc_ok_q  <= 1'b0;
         tmp_ok_q <= 1'b0;
      end else if (wr && ain == `LDR_A_MCLR) begin
         tc_ok_q  <= 1'b1;
         tmp_ok_q <= 1'b1;
      end else if (rd && ain == `LDR_A_CMD) begin
         tc_ok_q <= 1'b1;
      end
   end

   // Byte pointer model
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ptr_q  <= 1'b0;
         last_q <= 4'h0;
      end else if (wr && (ain == `LDR_A_CLRBP || ain == `LDR_A_MCLR)) begin
         ptr_q <= 1'b0;
      end else if ((rd || wr) && !ain[3]) begin
         ptr_q  <= !ptr_q;
         last_q <= ain;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   strobe_excl_a: assert property (!(!iorin_n && !iowin_n))
      else $error("read and write strobes together");
   write_select_a: assert property ((!iorin_n || !iowin_n) |-> !cs_n)
      else $error("strobe without chip select");
   read_hold_a: assert property (
      !hreq && !$past(hreq) && $changed(dbout) |-> $past(rd))
      else $error("read data changed without a read");
   grant_follow_a: assert property (hlda == $past(hreq))
      else $error("grant does not follow request");
   host_quiet_a: assert property ((rd || wr) |-> !hlda)
      else $error("register access while bus granted");
   tc_clear_a: assert property (
      rd && ain == `LDR_A_CMD && tc_ok_q |=> dbout[3:0] == 4'h0)
      else $error("terminal count bits not cleared");
   temp_clear_a: assert property (
      rd && ain == `LDR_A_MCLR && tmp_ok_q |=> dbout == 8'h00)
      else $error("temporary data not cleared");
   word_pair_a: assert property (
      (rd || wr) && !ain[3] && ptr_q |-> ain == last_q)
      else $error("high byte access to another register");

   cover property (rd && ain == `LDR_A_CMD);
   cover property (wr && ain == `LDR_A_CLRBP);
   cover property ($rose(hreq));
endmodule // ldr_link_monitor

`default_nettype wire

/* tb/legacy_dma_register_interface_tb.sv */
// Bench: host end and device end joined by the link interface.
// Assumes the host software port is the only way to the device.
`timescale 1ns/1ps
`default_nettype none
`include "ldr_defines.svh"

module legacy_dma_register_interface_tb;
   logic        clk_sys, reset, sw_wr, sw_rd;
   logic [1:0]  sw_addr;
   logic [15:0] sw_wdata, sw_rdata, aout;
   logic [3:0]  dreq, dack;
   logic [7:0]  mem_rdata;
   logic        aen, memr_n, memw_n, iorout_n, iowout_n, eopout_n;
   int          err_count, total_checks, xfers, eops, t_rd, t_wr;
   int          t_rr, t_wre;
   logic [15:0] a_seen;
   logic [4:0]  ak_seen;

   ldr_if bus ();
   ldr_host i_ldr_host (.clk_sys(clk_sys), .reset(reset), .bus(bus),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_rdata(sw_rdata));
   ldr_device i_ldr_device (.clk_sys(clk_sys), .reset(reset), .bus(bus),
      .dreq(dreq), .mem_rdata(mem_rdata), .dack(dack), .aout(aout),
      .aen(aen), .memr_n(memr_n), .memw_n(memw_n), .iorout_n(iorout_n),
      .iowout_n(iowout_n), .eopout_n(eopout_n));
   ldr_link_monitor i_ldr_link_monitor (.clk_sys(clk_sys), .reset(reset),
      .cs_n(bus.cs_n), .iorin_n(bus.iorin_n), .iowin_n(bus.iowin_n),
      .ain(bus.ain), .dbout(bus.dbout), .hreq(bus.hreq), .hlda(bus.hlda));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // Transfer strobe watchers
   always @(negedge iorout_n or negedge memr_n) begin
      xfers++;
      t_rd = int'($time);
   end
   always @(posedge iorout_n or posedge memr_n) t_rr = int'($time);
   always @(negedge memw_n or negedge iowout_n) begin
      t_wr = int'($time);
      a_seen = aout;
      ak_seen = {aen, dack};
   end
   always @(posedge memw_n or posedge iowout_n) t_wre = int'($time);
   always @(negedge clk_sys) if (eopout_n === 1'b0) eops++;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic sw_write(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= 1'b1;
      @(posedge clk_sys);
      sw_wr <= 1'b0;
   endtask

   task automatic sw_read(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      sw_addr <= a;
      sw_rd   <= 1'b1;
      @(posedge clk_sys);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
   endtask

   // One device access through the host, then wait until not busy
   task automatic dev_do(input logic [7:0] order, input logic [15:0] d);
      logic [15:0] s;
      sw_write(`LDR_H_DATA, d);
      sw_write(`LDR_H_CMD, {8'h00, order});
      for (int i = 0; i < 100; i++) begin
         sw_read(`LDR_H_CMD, s);
         if (s[0] === 1'b0) break;
      end
   endtask

   task automatic dev_rd(input logic [7:0] order, output logic [15:0] d);
      dev_do(order | 8'h20, 16'h0000);
      sw_read(`LDR_H_RES, d);
   endtask

   task automatic wait_eop;
      for (int i = 0; i < 400 && eops == 0; i++) @(posedge clk_sys);
      chk(16'(eops), 16'h0001);
   endtask

   task automatic t_reset_state;
      logic [15:0] v;
      dev_rd(8'h08, v);
      chk(v, 16'h0000);
      dev_rd(8'h0d, v);
      chk(v, 16'h0000);
   endtask

   task automatic t_word_regs;
      logic [15:0] v;
      dev_do(8'h12, 16'h1234);
      dev_do(8'h13, 16'h00ff);
      dev_rd(8'h12, v);
      chk(v, 16'h1234);
      dev_rd(8'h13, v);
      chk(v, 16'h00ff);
   endtask

   // Single mode, two hardware transfers, late write
   task automatic t_single;
      logic [15:0] v;
      dev_do(8'h08, 16'h0004);
      dev_do(8'h0d, 16'h0000);
      dev_do(8'h0b, 16'h0044);
      dev_do(8'h09, 16'h0004);
      sw_read(`LDR_H_CMD, v);
      chk(v, 16'h0002);
      dev_do(8'h10, 16'h0100);
      dev_do(8'h11, 16'h0001);
      dev_do(8'h0e, 16'h0000);
      xfers = 0;
      eops = 0;
      @(posedge clk_sys);
      dreq <= 4'h1;
      wait_eop;
      repeat (20) @(negedge clk_sys);
      chk(16'(bus.hreq), 16'h0000);
      chk(16'(xfers), 16'h0002);
      chk(16'(t_wr - t_rd), 16'h000c);
      chk(16'(t_rr - t_rd), 16'h0010);
      chk(a_seen, 16'h0101);
      chk(16'(ak_seen), 16'h001e);
      @(posedge clk_sys);
      dreq <= 4'h0;
      dev_rd(8'h10, v);
      chk(v, 16'h0102);
      dev_rd(8'h11, v);
      chk(v, 16'hffff);
      dev_rd(8'h08, v);
      chk(v, 16'h0001);
      dev_rd(8'h08, v);
      chk(v, 16'h0000);
   endtask

   // Block mode software request on a masked channel, auto-init
   task automatic t_block;
      logic [15:0] v;
      dev_do(8'h08, 16'h0020);
      dev_do(8'h0b, 16'h009a);
      dev_do(8'h14, 16'h2000);
      dev_do(8'h15, 16'h0002);
      dev_do(8'h0a, 16'h00fe);
      xfers = 0;
      eops = 0;
      dev_do(8'h09, 16'h00fe);
      wait_eop;
      chk(16'(xfers), 16'h0003);
      chk(16'(t_wr - t_rd), 16'h0004);
      dev_rd(8'h14, v);
      chk(v, 16'h2000);
      dev_rd(8'h15, v);
      chk(v, 16'h0002);
      dev_rd(8'h08, v);
      chk(v, 16'h0004);
   endtask

   // Compressed timing, active-high acknowledge, mask bit, decrement
   task automatic t_compress;
      logic [15:0] v;
      dev_do(8'h08, 16'h0088);
      dev_do(8'h0b, 16'h0067);
      dev_do(8'h16, 16'h3000);
      dev_do(8'h17, 16'h0000);
      dev_do(8'h0a, 16'h0007);
      xfers = 0;
      eops = 0;
      @(posedge clk_sys);
      dreq <= 4'hc;
      repeat (20) @(negedge clk_sys);
      chk(16'(bus.hreq), 16'h0000);
      dev_do(8'h0a, 16'h0003);
      wait_eop;
      chk(16'(xfers), 16'h0001);
      chk(16'(t_rr - t_rd), 16'h0008);
      chk(16'(t_wre - t_wr), 16'h0008);
      chk(a_seen, 16'h3000);
      chk(16'(ak_seen), 16'h0018);
      dev_rd(8'h16, v);
      chk(v, 16'h2fff);
      dev_rd(8'h08, v);
      chk(v, 16'h00c8);
      @(posedge clk_sys);
      dreq <= 4'h0;
   endtask

   task automatic summarize;
      $display("Checks %0d, errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      reset = 1'b1;
      sw_wr = 1'b0;
      sw_rd = 1'b0;
      sw_addr = 2'h0;
      sw_wdata = 16'h0000;
      dreq = 4'h0;
      mem_rdata = 8'h5a;
      err_count = 0;
      total_checks = 0;
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      t_reset_state;
      t_word_regs;
      t_single;
      t_block;
      t_compress;
      summarize;
   end

   initial begin
      #200000;
      err_count++;
      summarize;
   end
endmodule // legacy_dma_register_interface_tb

`default_nettype wire
